// ===== dv/spwm_channel_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "spwm_defs.svh"
// ----------------------------------
// port-level checks of one channel
// ----------------------------------
module spwm_channel_checker
  import spwm_pkg::*;
(
  // clock and reset
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic                 clk_en,
  // software side
  input wire spwm_pkg::spwm_byte_t wr_data,
  input wire logic                 wr_control,
  input wire logic                 wr_pin_direction,
  input wire logic                 clear_match_flag,
  input wire logic                 port_data,
  // observed outputs
  input wire spwm_pkg::spwm_byte_t duty_buffer_reg,
  input wire spwm_pkg::spwm_byte_t capture_pwm_control,
  input wire logic                 period_match_flag,
  input wire spwm_pkg::spwm_byte_t period_counter_view,
  input wire logic                 pwm_output_pin,
  input wire logic                 pwm_output_oe_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // mode decode; pin lags the registers by one cycle
  wire in_pwm = capture_pwm_control[3:0] == `SPWM_MODE_PWM;
  wire other  = capture_pwm_control != 8'h00 && !in_pwm;
  chk_reset_idle:
    assert property ($rose(rst_n) |-> pwm_output_oe_n && !pwm_output_pin && !period_match_flag)
    else $error("pin not idle after reset");
  chk_dir_to_oe:
    assert property (wr_pin_direction && clk_en ##1 clk_en && !wr_pin_direction
      |=> pwm_output_oe_n == $past(wr_data[0], 2))
    else $error("driver enable does not follow direction");
  chk_ctrl_read:
    assert property (wr_control && clk_en |=> capture_pwm_control == $past(wr_data))
    else $error("control readback wrong");
  chk_buffer_steady:
    assert property (in_pwm && !period_match_flag ##1 !period_match_flag
      |-> $stable(duty_buffer_reg))
    else $error("duty buffer moved between rollovers");
  chk_flag_sticky:
    assert property (period_match_flag && !(clear_match_flag && clk_en) |=> period_match_flag)
    else $error("match flag dropped without clear");
  chk_sleep_hold:
    assert property (!clk_en ##1 !clk_en |=> $stable(pwm_output_pin)
      && $stable(pwm_output_oe_n) && $stable(period_counter_view))
    else $error("state moved during sleep");
  chk_port_release:
    assert property (capture_pwm_control == 8'h00 && clk_en |=> pwm_output_pin == $past(port_data))
    else $error("released pin not port data");
  chk_off_mode_hold:
    assert property (other ##1 other |=> $stable(pwm_output_pin))
    else $error("pin moved outside modulation mode");
  // main scenarios reached
  cov_pulse: cover property ($rose(pwm_output_pin) && !pwm_output_oe_n);
  cov_flag: cover property ($rose(period_match_flag));
  cov_sleep: cover property ($fell(clk_en));
endmodule : spwm_channel_checker
bind spwm_channel spwm_channel_checker u_chk (.clock, .rst_n, .clk_en, .wr_data, .wr_control,
  .wr_pin_direction, .clear_match_flag, .port_data, .duty_buffer_reg, .capture_pwm_control,
  .period_match_flag, .period_counter_view, .pwm_output_pin, .pwm_output_oe_n);
`default_nettype wire

// ===== dv/spwm_load_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------
// load on the pin: pulse timing
// ----------------------------------
module spwm_load_model
(
  // clock and reset
  input  wire logic  clock,
  input  wire logic  rst_n,
  // pin as driven
  input  wire logic  pin,
  input  wire logic  oe_n,
  // last full pulse in clocks, rise count
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [15:0] rises
);
  logic        last;
  logic [15:0] hi_cnt;
  logic [15:0] per_cnt;
  // released pin falls to the pull-down of the load
  wire level = !oe_n && pin;
  wire rise  = level && !last;
  // lengths latch at each rise so a stalled pin keeps old figures
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {last, hi_cnt, per_cnt, hi_len, per_len, rises} <= '0;
    end
    else
    begin
      last    <= level;
      hi_cnt  <= rise ? 16'h0001 : hi_cnt + {15'h0, level};
      per_cnt <= rise ? 16'h0001 : per_cnt + 16'h0001;
      if (rise)
      begin
        hi_len  <= hi_cnt;
        per_len <= per_cnt;
        rises   <= rises + 16'h0001;
      end
    end
  end
endmodule : spwm_load_model
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------
// channel bench: write calls and pulse checks
// ----------------------------------
module testbench;
  import spwm_pkg::*;
  localparam int PER = 0, DHI = 1, DBUF = 2, CTL = 3, TSEL = 4, TCTL = 5, DIR = 6, CLR = 7;
  logic        clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, port_data = 1'b0;
  logic [1:0]  wr_timer_index = 2'h0;
  logic [7:0]  stb = 8'h00;
  spwm_byte_t  wr_data = 8'h00, duty_buffer_reg, capture_pwm_control, period_counter_view;
  logic        period_match_flag, pwm_output_pin, pwm_output_oe_n;
  logic [15:0] hi_len, per_len, rises;
  logic [8:0]  held;
  int          n_errors = 0, total_checks = 0;
  int          pre [3] = '{4, 16, 16};
  // 50 MHz clock
  always #10 clock = ~clock;
  spwm_channel DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .wr_data(wr_data),
    .wr_period(stb[PER]), .wr_duty_high(stb[DHI]), .wr_duty_buffer(stb[DBUF]),
    .wr_control(stb[CTL]), .wr_timer_select(stb[TSEL]), .wr_timer_control(stb[TCTL]),
    .wr_timer_index(wr_timer_index), .wr_pin_direction(stb[DIR]),
    .clear_match_flag(stb[CLR]), .port_data(port_data), .duty_buffer_reg(duty_buffer_reg),
    .capture_pwm_control(capture_pwm_control), .period_match_flag(period_match_flag),
    .period_counter_view(period_counter_view), .pwm_output_pin(pwm_output_pin),
    .pwm_output_oe_n(pwm_output_oe_n));
  spwm_load_model LOAD (.clock(clock), .rst_n(rst_n), .pin(pwm_output_pin),
    .oe_n(pwm_output_oe_n), .hi_len(hi_len), .per_len(per_len), .rises(rises));
  // comparison, write strobe and waits
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input int k, input spwm_byte_t d);
    @(posedge clock);
    stb     <= 8'(8'h01 << k);
    wr_data <= d;
    @(posedge clock);
    stb <= 8'h00;
  endtask : wr
  task automatic fresh_flag();
    int n;
    n = 0;
    wr(CLR, 8'h00);
    while (period_match_flag !== 1'b1 && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    cmp("match flag", 16'h1, {15'h0, period_match_flag});
  endtask : fresh_flag
  task automatic measure(input int hi, input int per);
    logic [15:0] r0;
    int          n;
    r0 = rises;
    n = 0;
    // third rise: the first may come from the driver switching on mid-pulse
    while (rises !== r0 + 16'h3 && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    cmp("measure limit", 16'h0, {15'h0, n >= 3000});
    cmp("high time", hi[15:0], hi_len);
    cmp("period", per[15:0], per_len);
  endtask : measure
  task automatic hold(input logic v, input int n);
    repeat (n)
    begin
      @(negedge clock);
      cmp("pin level", {15'h0, v}, {15'h0, pwm_output_pin});
    end
  endtask : hold
  task automatic idle_check();
    cmp("idle state", 16'h8000, {pwm_output_oe_n, pwm_output_pin, period_match_flag,
      5'h0, capture_pwm_control});
  endtask : idle_check
  task automatic give_verdict();
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // watchdog well beyond the longest sequence
  initial
  begin
    repeat (30000) @(posedge clock);
    n_errors++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    idle_check();
    wr(DIR, 8'h01);
    wr(PER, 8'h03);
    wr(CTL, 8'h2C);
    wr(DHI, 8'h01);
    wr(TSEL, 8'h00);
    wr(TCTL, 8'h04);
    fresh_flag();
    cmp("duty buffer", 16'h01, {8'h0, duty_buffer_reg});
    wr(DIR, 8'h00);
    repeat (2) @(negedge clock);
    cmp("driver enable", 16'h0, {15'h0, pwm_output_oe_n});
    measure(6, 16);
    for (int p = 1; p < 4; p++)
    begin
      wr(TCTL, 8'h04 | p[7:0]);
      measure(6 * pre[p-1], 16 * pre[p-1]);
    end
    wr(TCTL, 8'h04);
    fresh_flag();
    wr(DHI, 8'h02);
    wr(DBUF, 8'h55);
    cmp("duty buffer", 16'h01, {8'h0, duty_buffer_reg});
    measure(10, 16);
    cmp("duty buffer", 16'h02, {8'h0, duty_buffer_reg});
    wr(DHI, 8'h00);
    wr(CTL, 8'h0C);
    repeat (2) fresh_flag();
    hold(1'b0, 40);
    wr(DHI, 8'h20);
    repeat (2) fresh_flag();
    hold(1'b1, 40);
    wr(DHI, 8'h01);
    wr(CTL, 8'h2C);
    measure(6, 16);
    @(posedge clock);
    clk_en <= 1'b0;
    repeat (2) @(negedge clock);
    held = {pwm_output_pin, period_counter_view};
    wr(CTL, 8'h00); // refused while asleep
    repeat (20) @(negedge clock);
    cmp("frozen", {7'h0, held}, {7'h0, pwm_output_pin, period_counter_view});
    cmp("control", 16'h2C, {8'h0, capture_pwm_control});
    @(posedge clock);
    clk_en <= 1'b1;
    measure(6, 16);
    @(posedge clock);
    wr_timer_index <= 2'h1;
    wr(PER, 8'h01);
    wr(TCTL, 8'h04);
    wr(TSEL, 8'h01);
    measure(6, 8);
    wr(TSEL, 8'h03);
    measure(6, 16);
    wr(CTL, 8'h08);
    repeat (2) @(negedge clock);
    hold(pwm_output_pin, 20);
    @(posedge clock);
    port_data <= 1'b1;
    wr(CTL, 8'h00);
    repeat (2) @(negedge clock);
    cmp("released pin", 16'h1, {15'h0, pwm_output_pin});
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(negedge clock);
    idle_check();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// ===== hdl/spwm_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "spwm_defs.svh"
module spwm_channel
  import spwm_pkg::*;
(
  // clock, reset, sleep freeze
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // software writes: data with one-cycle strobes
  input  wire spwm_pkg::spwm_byte_t wr_data,
  input  wire logic                 wr_period,
  input  wire logic                 wr_duty_high,
  input  wire logic                 wr_duty_buffer,
  input  wire logic                 wr_control,
  input  wire logic                 wr_timer_select,
  input  wire logic                 wr_timer_control,
  input  wire logic [1:0]           wr_timer_index,
  input  wire logic                 wr_pin_direction,
  input  wire logic                 clear_match_flag,
  // port function of the pin when released
  input  wire logic                 port_data,
  // readback
  output spwm_pkg::spwm_byte_t      duty_buffer_reg,
  output spwm_pkg::spwm_byte_t      capture_pwm_control,
  output logic                      period_match_flag,
  output spwm_pkg::spwm_byte_t      period_counter_view,
  // pin
  output logic                      pwm_output_pin,
  output logic                      pwm_output_oe_n
);
  import spwm_pkg::*;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  spwm_byte_t period_register [3];
  spwm_pre_e  prescale_select [3];
  logic       timer_on        [3];
  spwm_byte_t duty_high_bits_reg;
  spwm_sel_t  timer_select;
  logic       pin_direction;
  logic [1:0] duty_low_latch;
  spwm_out_e  out_state;

  // ---------------------------------------------------------------
  // shared timers
  // ---------------------------------------------------------------
  spwm_byte_t tmr_count [3];
  logic [1:0] tmr_sub   [3];
  logic       tmr_roll  [3];
  logic       tmr_step  [3];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_tmr
      spwm_timer u_timer
      (
        .clock           (clock),
        .rst_n           (rst_n),
        .clk_en          (clk_en),
        .timer_on        (timer_on[gi]),
        .prescale_select (prescale_select[gi]),
        .period_register (period_register[gi]),
        .period_counter  (tmr_count[gi]),
        .sub_bits        (tmr_sub[gi]),
        .rollover        (tmr_roll[gi]),
        .step            (tmr_step[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // selection and decode
  // ---------------------------------------------------------------
  wire [1:0] sel_idx = (timer_select == 2'h3) ? 2'h0 : timer_select;
  wire [9:0] time_base = {tmr_count[sel_idx], tmr_sub[sel_idx]};
  wire [9:0] duty_buf  = {duty_buffer_reg, duty_low_latch};
  wire       sel_on    = timer_on[sel_idx];
  wire       sel_roll  = tmr_roll[sel_idx];
  wire       sel_step  = tmr_step[sel_idx];
  wire       pwm_mode  =
    (capture_pwm_control[`SPWM_CTRL_MODE_MSB:`SPWM_CTRL_MODE_LSB] == `SPWM_MODE_PWM);
  wire       released  = (capture_pwm_control == `SPWM_RST_BYTE);
  wire       active    = pwm_mode && sel_on && clk_en;
  // a new period's duty comes straight from the software registers
  wire [9:0] next_duty = {duty_high_bits_reg,
    capture_pwm_control[`SPWM_CTRL_DLOW_MSB:`SPWM_CTRL_DLOW_LSB]};
  // tick of the selected time base, one quarter step
  wire [9:0] next_base = sel_roll ? 10'h000 : time_base + 10'h001;
  // only a prescaled tick moves the time base; slower prescales hold it
  wire       base_step = active && sel_step;
  // high time is duty quarters long; compare with the next position
  wire       hit_clear = base_step && !sel_roll
                         && (next_base == duty_buf);
  wire       next_pin_level = released ? port_data
                              : (out_state == SPWM_OUT_HIGH);
  // rollover decides the new period's level from the freshly latched duty
  wire       start_high = (next_duty != 10'h000);

  // ---------------------------------------------------------------
  // timer configuration writes
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cfg
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          period_register[gi] <= `SPWM_RST_PERIOD;
          prescale_select[gi] <= SPWM_PRE_1;
          timer_on[gi]        <= 1'b0;
        end
        else if (clk_en && wr_timer_index == 2'(gi))
        begin
          if (wr_period)
            period_register[gi] <= wr_data;
          if (wr_timer_control)
          begin
            timer_on[gi]        <= wr_data[2];
            prescale_select[gi] <= spwm_pre_e'(wr_data[1:0]);
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // channel software registers
  // ---------------------------------------------------------------
  // writes land whenever clk_en is high; only the duty bits wait for the rollover to move on
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      duty_high_bits_reg  <= `SPWM_RST_BYTE;
      capture_pwm_control <= `SPWM_RST_BYTE;
      timer_select        <= 2'h0;
      pin_direction       <= `SPWM_RST_DIR;
    end
    else if (clk_en)
    begin
      if (wr_duty_high)
        duty_high_bits_reg <= wr_data;
      if (wr_control)
        capture_pwm_control <= wr_data;
      if (wr_timer_select)
        timer_select <= wr_data[1:0];
      if (wr_pin_direction)
        pin_direction <= wr_data[0];
    end
  end

  // ---------------------------------------------------------------
  // duty double buffer
  // ---------------------------------------------------------------
  // in PWM mode the buffer only moves at a period boundary, so no mid-period glitch
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      duty_buffer_reg <= `SPWM_RST_BYTE;
      duty_low_latch  <= 2'h0;
    end
    else if (active && sel_roll)
    begin
      duty_buffer_reg <= duty_high_bits_reg;
      duty_low_latch  <= next_duty[1:0];
    end
    else if (clk_en && wr_duty_buffer && !pwm_mode)
      duty_buffer_reg <= wr_data;
  end

  // ---------------------------------------------------------------
  // output state machine
  // ---------------------------------------------------------------
  // duty beyond the period never matches, so the level just holds
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      out_state <= SPWM_OUT_LOW;
    else if (active)
    begin
      case (out_state)
        SPWM_OUT_LOW:
          if (sel_roll && start_high)
            out_state <= SPWM_OUT_HIGH;
        SPWM_OUT_HIGH:
          if (sel_roll && !start_high)
            out_state <= SPWM_OUT_LOW;
          else if (hit_clear)
            out_state <= SPWM_OUT_LOW;
        default:
          out_state <= SPWM_OUT_LOW;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // flag and pin registers
  // ---------------------------------------------------------------
  // set beats a clear arriving in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_match_flag   <= 1'b0;
      pwm_output_pin      <= 1'b0;
      pwm_output_oe_n     <= 1'b1;
      period_counter_view <= `SPWM_RST_BYTE;
    end
    else if (clk_en)
    begin
      if (sel_roll)
        period_match_flag <= 1'b1;
      else if (clear_match_flag)
        period_match_flag <= 1'b0;
      pwm_output_pin      <= next_pin_level;
      pwm_output_oe_n     <= pin_direction;
      period_counter_view <= tmr_count[sel_idx];
    end
  end
endmodule : spwm_channel
`default_nettype wire

// ===== hdl/spwm_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "spwm_defs.svh"
// shared 8-bit period timer with prescaler; one instance per timer
module spwm_timer
  import spwm_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // configuration
  input  wire logic                 timer_on,
  input  wire spwm_pkg::spwm_pre_e  prescale_select,
  input  wire spwm_pkg::spwm_byte_t period_register,
  // state
  output spwm_pkg::spwm_byte_t      period_counter,
  output logic [1:0]                sub_bits,
  output logic                      rollover,
  output logic                      step
);
  logic [3:0] pre_count;
  logic [3:0] pre_limit;
  logic       tick;

  // --------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------
  // 1:1 gives a tick each clock, sub bits then follow the clock phase
  assign pre_limit = (prescale_select == SPWM_PRE_1) ? 4'h0 :
                     (prescale_select == SPWM_PRE_4) ? `SPWM_PRE_DIV4 :
                     `SPWM_PRE_DIV16;
  // four time-base quarters make one counter increment
  assign tick      = (pre_count == pre_limit);
  // one time-base step per prescaled tick, not per clock
  assign step      = timer_on && clk_en && tick;
  assign rollover  = step
                     && (sub_bits == 2'h3) && (period_counter == period_register);
  // postscaler deliberately absent: it never shapes the period

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_count      <= 4'h0;
      sub_bits       <= 2'h0;
      period_counter <= `SPWM_RST_BYTE;
    end
    else if (clk_en && timer_on)
    begin
      pre_count <= tick ? 4'h0 : pre_count + 4'h1;
      if (tick)
      begin
        sub_bits <= sub_bits + 2'h1;
        if (sub_bits == 2'h3)
          period_counter <= (period_counter == period_register)
                            ? 8'h00 : period_counter + 8'h01;
      end
    end
  end
endmodule : spwm_timer
`default_nettype wire

// ===== shared/spwm_defs.svh
`ifndef SPWM_DEFS_SVH
`define SPWM_DEFS_SVH

// ---------------------------------------------------------------
// field positions and widths
// ---------------------------------------------------------------
`define SPWM_CTRL_MODE_LSB   0
`define SPWM_CTRL_MODE_MSB   3
`define SPWM_CTRL_DLOW_LSB   4
`define SPWM_CTRL_DLOW_MSB   5
`define SPWM_MODE_PWM        4'hC
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SPWM_RST_BYTE        8'h00
`define SPWM_RST_PERIOD      8'hFF
`define SPWM_RST_DIR         1'b1
// ---------------------------------------------------------------
// timing counts: one time-base quarter per clock at prescale 1:1
// ---------------------------------------------------------------
`define SPWM_QUARTERS        4
`define SPWM_PRE_DIV4        4'h3
`define SPWM_PRE_DIV16       4'hF

`endif

// ===== shared/spwm_pkg.sv
package spwm_pkg;
  typedef logic [7:0] spwm_byte_t;
  typedef logic [1:0] spwm_sel_t;
  // prescale selection codes
  typedef enum logic [1:0]
  {
    SPWM_PRE_1  = 2'h0,
    SPWM_PRE_4  = 2'h1,
    SPWM_PRE_16 = 2'h2,
    SPWM_PRE_16B = 2'h3
  } spwm_pre_e;
  // output state, one-hot
  typedef enum logic [1:0]
  {
    SPWM_OUT_LOW  = 2'b01,
    SPWM_OUT_HIGH = 2'b10
  } spwm_out_e;
endpackage : spwm_pkg
